// ### hdl/rsc_pkg.sv
// constants and carrier types of the reset source controller
// Function
// - a reset line held low for more than 4 machine cycles, or power application, is an external reset.
// - power-on and pin resets give the same initialisation and restart path, with no flag between them.
// - a watchdog or clock-monitor failure drives the reset line low for fewer than 4 machine cycles.
// - after an internal reset the cause is known and the start address comes from that cause's vector; the code uses FFFE if the line is held past the drive.
// - exactly four reset causes exist: power, external line, clock-monitor failure, watchdog failure.
// - every reset initialises the configuration registers before the vector fetch begins.
// - power-on and pin resets fetch their start address from the shared vector FFFE.
// - watchdog and clock-monitor resets use their own vectors, distinct from the shared one.
// - an illegal instruction traps to the restart handler without a reset or a register reload.
// - an enabled watchdog resets the processor unless it is serviced within the selected time-out.
// - an enabled clock monitor resets the processor when the bus clock stops or fails.
// - the two-bit rate field selects 8.192, 32.768, 131.07 or 524.5 ms as time-out.
// - the clock monitor never resets above 200 kHz and always resets below 10 kHz.
// - the rate field takes writes only in the first 64 cycles after a reset.
package rsc_pkg;

    localparam real CLK_PERIOD_NS = 5.0;

    localparam logic [2:0] EXT_MIN_CYC = 3'h4;
    localparam logic [1:0] DRV_CYC = 2'h3;
    localparam logic [6:0] RATE_WIN_CYC = 7'h40;

    localparam logic [7:0] SVC_ARM = 8'h55;
    localparam logic [7:0] SVC_KICK = 8'hAA;

    localparam logic [15:0] VEC_SHARED = 16'hFFFE;
    localparam logic [15:0] VEC_WDOG_DEF = 16'hFFF0;
    localparam logic [15:0] VEC_CMON_DEF = 16'hFFF2;

    localparam real WD_TO0_MS = 8.192;
    localparam real WD_TO1_MS = 32.768;
    localparam real WD_TO2_MS = 131.07;
    localparam real WD_TO3_MS = 524.5;
    localparam int WD_CYC0 = $rtoi(WD_TO0_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam int WD_CYC1 = $rtoi(WD_TO1_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam int WD_CYC2 = $rtoi(WD_TO2_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam int WD_CYC3 = $rtoi(WD_TO3_MS * 1.0e6 / CLK_PERIOD_NS);

    localparam real CM_FAST_KHZ = 200.0;
    localparam real CM_SLOW_KHZ = 10.0;
    // trip on a stall of one slow half period, far above the fast one
    localparam int CM_LIM_CYC = $rtoi(1.0e6 / (2.0 * CM_SLOW_KHZ)
                                      / CLK_PERIOD_NS);
    localparam int CM_FAST_HALF_CYC = $rtoi(1.0e6 / (2.0 * CM_FAST_KHZ)
                                            / CLK_PERIOD_NS);

    localparam int WD_W = 27;
    localparam int CM_W = 16;

    typedef enum logic [1:0] {
        RSC_ST_EXT,
        RSC_ST_DRIVE,
        RSC_ST_SAMPLE,
        RSC_ST_RUN
    } rsc_phase_e;

    typedef struct packed {
        logic req;
        logic [15:0] addr;
    } rsc_fetch_s;

    typedef struct packed {
        logic wdog;
        logic cmon;
    } rsc_cause_s;

endpackage : rsc_pkg

// ### hdl/rsc_reset_source_controller.sv
// reset source controller: filters, drives and vectors the reset line
`timescale 1ns/100ps
`default_nettype none
module rsc_reset_source_controller #(
    parameter int WD_T0 = rsc_pkg::WD_CYC0,
    parameter int WD_T1 = rsc_pkg::WD_CYC1,
    parameter int WD_T2 = rsc_pkg::WD_CYC2,
    parameter int WD_T3 = rsc_pkg::WD_CYC3,
    parameter int CM_LIM = rsc_pkg::CM_LIM_CYC,
    parameter logic [15:0] VEC_WDOG = rsc_pkg::VEC_WDOG_DEF,
    parameter logic [15:0] VEC_CMON = rsc_pkg::VEC_CMON_DEF
) (
    // clock and power-on reset
    input wire logic clk,
    input wire logic nrst,
    // shared open-drain reset line
    input wire logic rst_line_in,
    output logic rst_line_out,
    output logic rst_line_oe_n,
    // watchdog_unit control
    input wire logic wdog_en,
    input wire logic rate_wr,
    input wire logic timeout_select_lo,
    input wire logic timeout_select_hi,
    input wire logic svc_wr,
    input wire logic [7:0] watchdog_service_reg,
    // clock monitor
    input wire logic cmon_en,
    input wire logic bus_clk_in,
    // core side
    input wire logic illegal_op,
    output logic core_rst,
    output logic cfg_init,
    output rsc_pkg::rsc_fetch_s fetch,
    output rsc_pkg::rsc_cause_s cause,
    output logic trap_restart
);
    import rsc_pkg::*;

    generate
        if (WD_T0 < 2 || WD_T3 >= (1 << WD_W) || WD_T1 < WD_T0
            || WD_T2 < WD_T1 || WD_T3 < WD_T2) begin : g_bad_wd
            $error("watchdog time-out counts out of range");
        end
        if (CM_LIM <= CM_FAST_HALF_CYC || CM_LIM >= (1 << CM_W))
        begin : g_bad_cm
            $error("clock monitor limit out of range");
        end
    endgenerate

    function automatic logic [WD_W-1:0] wd_limit(input logic [1:0] sel);
        logic [WD_W-1:0] lim;
        lim = WD_W'(WD_T0);
        unique case (sel)
            2'h0: lim = WD_W'(WD_T0);
            2'h1: lim = WD_W'(WD_T1);
            2'h2: lim = WD_W'(WD_T2);
            2'h3: lim = WD_W'(WD_T3);
        endcase
        return lim;
    endfunction : wd_limit

    rsc_phase_e st_r;
    rsc_phase_e st_nxt;
    logic init_r;
    logic init_nxt;
    logic [2:0] ext_cnt_r;
    logic [2:0] ext_cnt_nxt;
    logic [1:0] drv_cnt_r;
    logic [6:0] win_cnt_r;
    logic [1:0] rate_r;
    logic arm_r;
    logic [WD_W-1:0] wd_cnt_r;
    logic bus_clk_d_r;
    logic [CM_W-1:0] cm_cnt_r;
    rsc_cause_s cause_nxt;
    logic core_rst_r;
    logic cfg_init_r;
    logic oe_n_r;
    logic line_out_r;
    rsc_fetch_s fetch_r;
    rsc_cause_s cause_r;
    logic trap_r;

    // decoding
    wire running = (st_r == RSC_ST_RUN) && !init_r;
    wire line_low = !rst_line_in;
    wire ext_trip = running && line_low
                    && (ext_cnt_r == EXT_MIN_CYC);
    wire rate_ok = running && rate_wr
                   && (win_cnt_r < RATE_WIN_CYC);
    wire svc_arm = svc_wr && (watchdog_service_reg == SVC_ARM);
    wire svc_kick = svc_wr && arm_r
                    && (watchdog_service_reg == SVC_KICK);
    wire [WD_W-1:0] wd_lim = wd_limit(rate_r);
    wire wd_fail = running && wdog_en && (wd_cnt_r == wd_lim);
    wire cm_edge = bus_clk_in != bus_clk_d_r;
    wire cm_fail = running && cmon_en
                   && (cm_cnt_r == CM_W'(CM_LIM));
    wire int_fail = !ext_trip && (wd_fail || cm_fail);
    wire drv_done = (st_r == RSC_ST_DRIVE) && (drv_cnt_r == DRV_CYC - 2'h1);
    wire fetch_go = (st_r == RSC_ST_RUN) && init_r;
    wire [15:0] vec_sel = cause_r.wdog ? VEC_WDOG :
                          cause_r.cmon ? VEC_CMON : VEC_SHARED;

    // sequencing of the reset phases
    always_comb begin
        st_nxt = st_r;
        init_nxt = init_r;
        cause_nxt = cause_r;
        unique case (st_r)
            RSC_ST_EXT: begin
                // power-up and pin resets share this path
                cause_nxt = '0;
                if (!line_low) begin
                    st_nxt = RSC_ST_RUN;
                    init_nxt = 1'b1;
                end
            end
            RSC_ST_DRIVE: begin
                if (drv_done) begin
                    st_nxt = RSC_ST_SAMPLE;
                end
            end
            RSC_ST_SAMPLE: begin
                // someone else still holds the line: treat as external
                if (line_low) begin
                    st_nxt = RSC_ST_EXT;
                    cause_nxt = '0;
                end else begin
                    st_nxt = RSC_ST_RUN;
                    init_nxt = 1'b1;
                end
            end
            RSC_ST_RUN: begin
                if (init_r) begin
                    init_nxt = 1'b0;
                end else if (ext_trip) begin
                    st_nxt = RSC_ST_EXT;
                end else if (int_fail) begin
                    st_nxt = RSC_ST_DRIVE;
                    // clock failure wins when both fire together
                    cause_nxt.cmon = cm_fail;
                    cause_nxt.wdog = !cm_fail;
                end
            end
        endcase
    end

    assign ext_cnt_nxt = (running && line_low) ? ext_cnt_r + 3'h1 : 3'h0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= RSC_ST_EXT;
            init_r <= 1'b0;
            cause_r <= '0;
        end else begin
            st_r <= st_nxt;
            init_r <= init_nxt;
            cause_r <= cause_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_cnt_r <= 3'h0;
            drv_cnt_r <= 2'h0;
        end else begin
            ext_cnt_r <= ext_trip ? 3'h0 : ext_cnt_nxt;
            drv_cnt_r <= (st_r == RSC_ST_DRIVE) ? drv_cnt_r + 2'h1 : 2'h0;
        end
    end

    // line drive: short pulse so outside filters do not see a pin reset
    always_ff @(posedge clk or negedge nrst) begin
        // open-drain data stays low; only the enable moves
        if (!nrst) begin
            oe_n_r <= 1'b1;
            line_out_r <= 1'b0;
        end else begin
            oe_n_r <= !(st_nxt == RSC_ST_DRIVE);
            line_out_r <= 1'b0;
        end
    end

    // core held through every reset phase and the init cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            core_rst_r <= 1'b1;
            cfg_init_r <= 1'b0;
            fetch_r <= '0;
        end else begin
            core_rst_r <= (st_nxt != RSC_ST_RUN) || init_nxt;
            cfg_init_r <= init_nxt && !init_r;
            fetch_r.req <= fetch_go;
            fetch_r.addr <= fetch_go ? vec_sel : fetch_r.addr;
        end
    end

    // trap restarts the core without touching the line
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trap_r <= 1'b0;
        end else begin
            trap_r <= running && illegal_op && !ext_trip
                      && !int_fail;
        end
    end

    // rate field: reloaded on every reset, locked after the window
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            win_cnt_r <= 7'h00;
            rate_r <= 2'h0;
        end else if (!running) begin
            win_cnt_r <= 7'h00;
            rate_r <= 2'h0;
        end else begin
            if (win_cnt_r < RATE_WIN_CYC) begin
                win_cnt_r <= win_cnt_r + 7'h01;
            end
            if (rate_ok) begin
                rate_r <= {timeout_select_hi, timeout_select_lo};
            end
        end
    end

    // watchdog_unit: any other value leaves the arm state alone
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            arm_r <= 1'b0;
            wd_cnt_r <= '0;
        end else if (!running || !wdog_en) begin
            arm_r <= 1'b0;
            wd_cnt_r <= '0;
        end else begin
            if (svc_arm) begin
                arm_r <= 1'b1;
            end else if (svc_kick) begin
                arm_r <= 1'b0;
            end
            wd_cnt_r <= svc_kick ? '0 : wd_cnt_r + WD_W'(1);
        end
    end

    // clock monitor: stall length between bus clock transitions
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_clk_d_r <= 1'b0;
            cm_cnt_r <= '0;
        end else begin
            bus_clk_d_r <= bus_clk_in;
            if (!running || !cmon_en || cm_edge) begin
                cm_cnt_r <= '0;
            end else if (cm_cnt_r != CM_W'(CM_LIM)) begin
                cm_cnt_r <= cm_cnt_r + CM_W'(1);
            end
        end
    end

    assign rst_line_out = line_out_r;
    assign rst_line_oe_n = oe_n_r;
    assign core_rst = core_rst_r;
    assign cfg_init = cfg_init_r;
    assign fetch = fetch_r;
    assign cause = cause_r;
    assign trap_restart = trap_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_ext_filter: assert property (
        (running && line_low && !init_r)[*5] |=> core_rst_r)
        else $error("long low on reset line not taken");
    a_ext_short: assert property (
        running && !wd_fail && !cm_fail && ext_cnt_r < EXT_MIN_CYC
        |=> !core_rst_r)
        else $error("short low on reset line caused reset");
    a_drive_len: assert property (
        $fell(oe_n_r) |-> !oe_n_r[*3] ##1 oe_n_r)
        else $error("reset drive length wrong");
    a_fail_drive: assert property (
        int_fail |=> !oe_n_r && core_rst_r)
        else $error("internal failure did not drive line");
    a_init_first: assert property (
        fetch_r.req |-> $past(cfg_init_r))
        else $error("vector fetch without prior init");
    a_shared_vec: assert property (
        fetch_r.req && !cause_r.wdog && !cause_r.cmon
        |-> fetch_r.addr == VEC_SHARED)
        else $error("external reset used wrong vector");
    a_own_vec: assert property (
        fetch_r.req && (cause_r.wdog || cause_r.cmon)
        |-> fetch_r.addr == (cause_r.wdog ? VEC_WDOG : VEC_CMON)
            && fetch_r.addr != VEC_SHARED)
        else $error("internal reset used wrong vector");
    a_one_cause: assert property (
        !(cause_r.wdog && cause_r.cmon))
        else $error("two reset causes at once");
    a_trap_quiet: assert property (
        trap_r |-> oe_n_r && !core_rst_r && !cfg_init_r)
        else $error("trap disturbed reset logic");
    a_rate_lock: assert property (
        win_cnt_r == RATE_WIN_CYC && running |=> $stable(rate_r))
        else $error("rate field changed after window");
    a_sample_ext: assert property (
        st_r == RSC_ST_SAMPLE && line_low |=> st_r == RSC_ST_EXT
        && cause_r == '0)
        else $error("held line not taken as external");

    c_wdog_reset: cover property (
        fetch_r.req && cause_r.wdog);
    c_cmon_reset: cover property (
        fetch_r.req && cause_r.cmon);
    c_ext_reset: cover property (
        ext_trip ##[1:600] fetch_r.req);
    c_trap: cover property (trap_r);

endmodule : rsc_reset_source_controller
`default_nettype wire

// ### testbench/rsc_line_partner.sv
// reset line parties: pull-up, push-button and peripherals
`timescale 1ns/100ps
`default_nettype none
module rsc_line_partner (
    // clock
    input wire logic clk,
    // device side of the line
    input wire logic dev_out,
    input wire logic dev_oe_n,
    // bench commands
    input wire logic go,
    input wire logic [15:0] len,
    input wire logic stretch,
    // wired level
    output logic line
);
    logic [15:0] cnt_r = 16'h0000;
    logic dev_low;
    assign dev_low = !dev_oe_n && !dev_out;
    // open collector only pulls low; the pull-up gives the high
    assign line = !(dev_low || cnt_r != 16'h0000);
    always @(posedge clk) begin
        if (go)
            cnt_r <= len;
        // a slow peripheral keeps the line low past the device's pulse
        else if (dev_low && stretch)
            cnt_r <= 16'h0008;
        else if (cnt_r != 16'h0000)
            cnt_r <= cnt_r - 16'h0001;
    end
endmodule : rsc_line_partner
`default_nettype wire

// ### testbench/rsc_reset_source_controller_test.sv
// self-checking bench of the reset source controller
`timescale 1ns/100ps
`default_nettype none
module rsc_reset_source_controller_test;
    import rsc_pkg::*;
    localparam int TW [4] = '{100, 200, 300, 400};
    localparam int CM = 800;
    logic clk = 1'b0, nrst = 1'b0, go = 1'b0, stretch = 1'b0;
    logic wdog_en = 1'b0, rate_wr = 1'b0, sel_lo = 1'b0, sel_hi = 1'b0;
    logic svc_wr = 1'b0, cmon_en = 1'b0, bclk = 1'b0, illegal_op = 1'b0;
    logic bclk_run = 1'b1, slow = 1'b0, seeded = 1'b0;
    logic [7:0] svc_val = 8'h00;
    logic [15:0] len = 16'h0000;
    logic line, lout, oe_n, core_rst, cfg_init, trap;
    rsc_fetch_s fetch;
    rsc_cause_s cause;
    int errors = 0, num_checks = 0, nfetch = 0, ncr = 0, n, k;

    always #2.5 clk = !clk;

    rsc_reset_source_controller #(
        .WD_T0(TW[0]), .WD_T1(TW[1]), .WD_T2(TW[2]), .WD_T3(TW[3]),
        .CM_LIM(CM)
    ) dut (
        .clk(clk), .nrst(nrst), .rst_line_in(line), .rst_line_out(lout),
        .rst_line_oe_n(oe_n), .wdog_en(wdog_en), .rate_wr(rate_wr),
        .timeout_select_lo(sel_lo), .timeout_select_hi(sel_hi),
        .svc_wr(svc_wr), .watchdog_service_reg(svc_val),
        .cmon_en(cmon_en), .bus_clk_in(bclk), .illegal_op(illegal_op),
        .core_rst(core_rst), .cfg_init(cfg_init), .fetch(fetch),
        .cause(cause), .trap_restart(trap)
    );

    rsc_line_partner partner (
        .clk(clk), .dev_out(lout), .dev_oe_n(oe_n), .go(go), .len(len),
        .stretch(stretch), .line(line)
    );

    // bus clock: random fast toggling, or the slowest legal rate
    initial begin
        wait (seeded);
        forever begin
            repeat (slow ? CM_FAST_HALF_CYC : 1 + $urandom % 40)
                @(posedge clk);
            if (bclk_run)
                bclk <= !bclk;
        end
    end

    // counted on the falling edge, where outputs have settled
    always @(negedge clk) begin
        if (fetch.req === 1'b1)
            nfetch <= nfetch + 1;
        if (core_rst === 1'b1)
            ncr <= ncr + 1;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    // waits for the vector fetch, noting drive length and init pulse
    task automatic expect_reset(input logic [15:0] v, input logic [1:0] c,
                                input int d, input int lim, output int m);
        int drv;
        logic ini;
        m = 0;
        drv = 0;
        ini = 1'b0;
        do begin
            @(negedge clk);
            m++;
            if (oe_n === 1'b0)
                drv++;
            if (cfg_init === 1'b1)
                ini = 1'b1;
            if (m > lim) begin
                chk("fetch_timeout", 1, 0);
                end_sim();
            end
        end while (fetch.req !== 1'b1);
        chk("vector", v, fetch.addr);
        chk("cause", c, cause);
        chk("init_first", 1, ini);
        chk("drive_len", d, drv);
    endtask : expect_reset

    // gap after each pull keeps successive glitches apart
    task automatic pull(input logic [15:0] c);
        @(posedge clk);
        go <= 1'b1;
        len <= c;
        @(posedge clk);
        go <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : pull

    task automatic svc(input logic [7:0] v);
        @(posedge clk);
        svc_wr <= 1'b1;
        svc_val <= v;
        @(posedge clk);
        svc_wr <= 1'b0;
    endtask : svc

    initial begin
        void'($urandom(38));
        seeded = 1'b1;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        expect_reset(VEC_SHARED, 2'b00, 0, 50, n);
        $display("test power_on done");
        @(posedge clk);
        illegal_op <= 1'b1;
        @(posedge clk);
        illegal_op <= 1'b0;
        @(negedge clk);
        chk("trap", 1, trap);
        chk("line_idle", 1, oe_n);
        chk("core_run", 0, core_rst);
        repeat (10) @(negedge clk);
        chk("no_fetch", 1, nfetch);
        $display("test trap done");
        k = ncr;
        pull(16'h0004);
        repeat (3) pull(16'($urandom_range(1, 3)));
        chk("glitch_ignored", k, ncr);
        pull(16'h0190);
        expect_reset(VEC_SHARED, 2'b00, 0, 600, n);
        $display("test pin_reset done");
        for (int r = 0; r < 4; r++) begin
            @(posedge clk);
            wdog_en <= 1'b1;
            rate_wr <= 1'b1;
            sel_lo <= r[0];
            sel_hi <= r[1];
            @(posedge clk);
            rate_wr <= 1'b0;
            expect_reset(VEC_WDOG_DEF, 2'b10, DRV_CYC, TW[r] + 16, n);
            chk("wdog_period", 1, n >= TW[r]);
        end
        // late write of the slowest rate must not delay the trip
        repeat (70) @(posedge clk);
        rate_wr <= 1'b1;
        sel_lo <= 1'b1;
        sel_hi <= 1'b1;
        @(posedge clk);
        rate_wr <= 1'b0;
        expect_reset(VEC_WDOG_DEF, 2'b10, DRV_CYC, TW[0] - 50, n);
        $display("test wdog_rates done");
        @(negedge clk);
        k = nfetch;
        repeat (8) begin
            svc(SVC_ARM);
            repeat ($urandom_range(1, 20)) @(posedge clk);
            svc(SVC_KICK);
            repeat (40) @(posedge clk);
        end
        chk("serviced", k, nfetch);
        svc(SVC_KICK);
        svc(SVC_ARM);
        expect_reset(VEC_WDOG_DEF, 2'b10, DRV_CYC, TW[0] + 16, n);
        $display("test wdog_service done");
        @(posedge clk);
        stretch <= 1'b1;
        expect_reset(VEC_SHARED, 2'b00, DRV_CYC, TW[0] + 40, n);
        $display("test held_line done");
        @(posedge clk);
        wdog_en <= 1'b0;
        stretch <= 1'b0;
        cmon_en <= 1'b1;
        @(negedge clk);
        k = nfetch;
        repeat (1000) @(negedge clk);
        slow = 1'b1;
        repeat (2500) @(negedge clk);
        chk("cmon_quiet", k, nfetch);
        slow = 1'b0;
        bclk_run = 1'b0;
        // bus clock frozen: restart the stall count at a known edge
        @(posedge clk);
        cmon_en <= 1'b0;
        @(posedge clk);
        cmon_en <= 1'b1;
        expect_reset(VEC_CMON_DEF, 2'b01, DRV_CYC, CM + 60, n);
        chk("cmon_delay", 1, n >= CM - 45);
        @(posedge clk);
        cmon_en <= 1'b0;
        bclk_run = 1'b1;
        $display("test clock_monitor done");
        @(posedge clk);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        expect_reset(VEC_SHARED, 2'b00, 0, 50, n);
        $display("test second_power_on done");
        end_sim();
    end
endmodule : rsc_reset_source_controller_test
`default_nettype wire
